// ---- logic/adc_ctrl_defs.svh ----
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH
`define LATENCY_CYCLES   9
`define HALF_STAGES      10
`define CM_DEFAULT       3'h3
`define CM_MAX           3'h6
`define FRAME_BITS       16
`define WR_BIT           1'h0
`define REG_FMT          7'h01
`define REG_DIV          7'h06
`define REG_CM           7'h08
`define REG_RST          7'h0a
`define RST_KEY          8'h5a
`endif

// ---- logic/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;
   typedef enum logic [1:0] {TRI_LOW = 2'h0, TRI_HIGH = 2'h1, TRI_FLOAT = 2'h2} tri_t;
   typedef enum logic [1:0] {FMT_TWOS = 2'h0, FMT_BIN = 2'h1, FMT_GRAY = 2'h2} fmt_t;
   typedef enum logic [1:0] {DIV_1 = 2'h0, DIV_2 = 2'h1, DIV_4 = 2'h2} div_t;
   typedef enum logic [1:0] {BUS_DUAL = 2'h0, BUS_MUX_A = 2'h1, BUS_MUX_B = 2'h2} bus_t;
   typedef struct packed
   {
      fmt_t       fmt;
      div_t       div;
      bus_t       bus;
      logic [2:0] cm_sel;
      logic       bias_en;
   } cfg_t;
   typedef struct packed
   {
      logic [7:0] a;
      logic [7:0] b;
   } pair_t;
endpackage

// ---- logic/adc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.svh"
module adc_ctrl
   import adc_ctrl_pkg::*;
#(
   parameter int W = 8
)
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       serial_port_enable_n,
   input  wire tri_t       serial_in_or_format_strap,
   input  wire tri_t       div_strap,
   input  wire tri_t       port_select_or_bus_mode_strap,
   input  wire logic       power_down_input,
   input  wire pair_t      sample_in,
   input  wire logic       sample_valid,
   output logic            sdo_oe_n,
   output logic            sdo,
   output cfg_t            cfg,
   output pair_t           data_out,
   output logic            data_valid,
   output logic            chan_a_output_clock
);
   // Level-high serial_port_enable_n selects strap mode
   logic        strap_mode;
   logic        sclk;
   logic        sclk_d;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        cs_n;
   logic        sdin;
   logic        pd_d;
   logic        pd_fall;
   logic [4:0]  bit_cnt;
   logic [15:0] shift;
   logic [7:0]  wr_data;
   logic [7:0]  rd_word;
   logic [7:0]  rd_data;
   logic        rd_frame;
   fmt_t        reg_fmt;
   div_t        reg_div;
   logic [2:0]  reg_cm;
   logic        reg_bias;
   logic        soft_rst;
   pair_t       pipe [`HALF_STAGES];
   logic [`HALF_STAGES-1:0] vpipe;
   logic        phase;

   function automatic logic [7:0] fmt_code(input logic [7:0] twos, input fmt_t f);
      logic [7:0] bin;
      bin = {~twos[7], twos[6:0]};
      case (f)
         FMT_BIN:  fmt_code = bin;
         FMT_GRAY: fmt_code = bin ^ {1'h0, bin[7:1]};
         default:  fmt_code = twos;
      endcase
   endfunction

   assign strap_mode = serial_port_enable_n;
   assign sdin  = (serial_in_or_format_strap == TRI_HIGH);
   assign sclk  = (div_strap == TRI_HIGH);
   assign cs_n  = (port_select_or_bus_mode_strap != TRI_LOW);
   assign sclk_rise = sclk & ~sclk_d;
   assign sclk_fall = ~sclk & sclk_d;
   assign pd_fall   = pd_d & ~power_down_input;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         sclk_d <= 1'h0;
         pd_d   <= 1'h0;
      end
      else
      begin
         sclk_d <= sclk;
         pd_d   <= power_down_input;
      end
   end

   // Serial frame shifter; pins sampled on core_clk so SCLK must be slow
   always_ff @(posedge core_clk)
   begin
      if (!rst_n || strap_mode || cs_n)
      begin
         bit_cnt  <= 5'h0;
         shift    <= 16'h0;
         rd_frame <= 1'h0;
      end
      else if (sclk_rise && bit_cnt < 5'(`FRAME_BITS))
      begin
         shift   <= {shift[14:0], sdin};
         bit_cnt <= bit_cnt + 5'h1;
         if (bit_cnt == 5'h0)
            rd_frame <= (sdin != `WR_BIT);
      end
   end

   // At the last rise the address sits one bit below the command bit
   assign wr_data  = {shift[6:0], sdin};
   assign soft_rst = !strap_mode && !cs_n && sclk_rise && !rd_frame
                     && bit_cnt == 5'(`FRAME_BITS - 1)
                     && shift[13:7] == `REG_RST && wr_data == `RST_KEY;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n || soft_rst || (strap_mode && pd_fall))
      begin
         reg_fmt  <= FMT_TWOS;
         reg_div  <= DIV_1;
         reg_cm   <= `CM_DEFAULT;
         reg_bias <= 1'h0;
      end
      else if (!strap_mode && !cs_n && sclk_rise && !rd_frame
               && bit_cnt == 5'(`FRAME_BITS - 1))
      begin
         case (shift[13:7])
            `REG_FMT: reg_fmt <= fmt_t'(wr_data[2:1]);
            `REG_DIV: reg_div <= div_t'(wr_data[1:0]);
            `REG_CM:
            begin
               if (wr_data[2:0] <= `CM_MAX)
                  reg_cm <= wr_data[2:0];
               reg_bias <= wr_data[7];
            end
            default: ;
         endcase
      end
   end

   always_comb
   begin
      case (shift[6:0])
         `REG_FMT: rd_word = {5'h0, reg_fmt, 1'h0};
         `REG_DIV: rd_word = {6'h0, reg_div};
         `REG_CM:  rd_word = {reg_bias, 4'h0, reg_cm};
         default:  rd_word = 8'h0;
      endcase
   end

   // Read data driven out after the eighth rising edge, MSB first
   always_ff @(posedge core_clk)
   begin
      if (!rst_n || strap_mode || cs_n)
      begin
         sdo      <= 1'h0;
         sdo_oe_n <= 1'h1;
         rd_data  <= 8'h0;
      end
      else if (sclk_fall && rd_frame && bit_cnt == 5'h8)
      begin
         // MSB goes out on this same fall, the rest on later falls
         rd_data  <= {rd_word[6:0], 1'h0};
         sdo_oe_n <= 1'h0;
         sdo      <= rd_word[7];
      end
      else if (sclk_fall && !sdo_oe_n)
      begin
         sdo     <= rd_data[7];
         rd_data <= {rd_data[6:0], 1'h0};
      end
   end

   // Strap decode held stable by sampling only while strap mode is active
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         cfg <= '{fmt: FMT_TWOS, div: DIV_1, bus: BUS_DUAL, cm_sel: `CM_DEFAULT, bias_en: 1'h0};
      else if (strap_mode)
      begin
         cfg.fmt     <= fmt_t'(serial_in_or_format_strap);
         cfg.div     <= div_t'(div_strap);
         cfg.bus     <= bus_t'(port_select_or_bus_mode_strap);
         cfg.cm_sel  <= reg_cm;
         cfg.bias_en <= reg_bias;
      end
      else
         cfg <= '{fmt: reg_fmt, div: reg_div, bus: BUS_DUAL, cm_sel: reg_cm,
                  bias_en: reg_bias};
   end

   // Ten half-cycle stages modelled as one per core_clk rising edge
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         phase <= 1'h0;
         vpipe <= '0;
      end
      else
      begin
         phase <= ~phase;
         vpipe <= {vpipe[`HALF_STAGES-2:0], sample_valid};
      end
   end

   generate
      for (genvar i = 0; i < `HALF_STAGES; i++)
      begin : g_stage
         if (i == 0)
         begin : g_first
            always_ff @(posedge core_clk)
            begin
               if (!rst_n)
                  pipe[i] <= '0;
               else
                  pipe[i] <= sample_in;
            end
         end
         else
         begin : g_next
            always_ff @(posedge core_clk)
            begin
               if (!rst_n)
                  pipe[i] <= '0;
               else
                  pipe[i] <= pipe[i-1];
            end
         end
      end
   endgenerate

   // Stage 8 plus output register gives nine cycles
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         data_out   <= '0;
         data_valid <= 1'h0;
      end
      else
      begin
         data_valid <= vpipe[`LATENCY_CYCLES-2];
         case (cfg.bus)
            BUS_MUX_A: data_out <= phase ?
               '{a: fmt_code(pipe[`LATENCY_CYCLES-2].b, cfg.fmt), b: 8'h0} :
               '{a: fmt_code(pipe[`LATENCY_CYCLES-2].a, cfg.fmt), b: 8'h0};
            BUS_MUX_B: data_out <= phase ?
               '{a: 8'h0, b: fmt_code(pipe[`LATENCY_CYCLES-2].b, cfg.fmt)} :
               '{a: 8'h0, b: fmt_code(pipe[`LATENCY_CYCLES-2].a, cfg.fmt)};
            default: data_out <= '{a: fmt_code(pipe[`LATENCY_CYCLES-2].a, cfg.fmt),
                                   b: fmt_code(pipe[`LATENCY_CYCLES-2].b, cfg.fmt)};
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         chan_a_output_clock <= 1'h0;
      else
         chan_a_output_clock <= phase;
   end
endmodule
`default_nettype wire

// ---- verif/adc_rx_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_rx_model
   import adc_ctrl_pkg::*;
(
   input wire logic  core_clk,
   input wire pair_t data_out,
   input wire logic  data_valid,
   input wire logic  chan_a_output_clock
);
   pair_t got[$];
   logic  ph[$];
   // Capture on the edge, as a registered receiver would
   always @(posedge core_clk)
      if (data_valid === 1'h1)
      begin
         got.push_back(data_out);
         ph.push_back(chan_a_output_clock);
      end
endmodule
`default_nettype wire

// ---- verif/adc_ctrl_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.svh"
module adc_ctrl_chk
   import adc_ctrl_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic serial_port_enable_n,
   input wire tri_t serial_in_or_format_strap,
   input wire tri_t div_strap,
   input wire tri_t port_select_or_bus_mode_strap,
   input wire logic power_down_input,
   input wire logic sample_valid,
   input wire cfg_t cfg,
   input wire logic data_valid,
   input wire logic sdo_oe_n,
   input wire logic chan_a_output_clock
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_strap;
      serial_port_enable_n;
   endsequence
   sequence s_quiet;
      !serial_port_enable_n && port_select_or_bus_mode_strap != TRI_LOW;
   endsequence
   a_strap_fmt: assert property (s_strap |=>
      cfg.fmt == fmt_t'($past(serial_in_or_format_strap))) else $error("fmt strap");
   a_strap_div: assert property (s_strap |=>
      cfg.div == div_t'($past(div_strap))) else $error("div strap");
   a_strap_bus: assert property (s_strap |=>
      cfg.bus == bus_t'($past(port_select_or_bus_mode_strap))) else $error("bus strap");
   a_serial_dual: assert property (!serial_port_enable_n |=>
      cfg.bus == BUS_DUAL) else $error("serial bus");
   // Four cycles of margin covers the frame tail write
   a_idle_cfg_stable: assert property (s_quiet [*4] |-> $stable(cfg)) else $error("cfg moved");
   a_cm_reset: assert property ($rose(rst_n) |->
      cfg.cm_sel == `CM_DEFAULT && !cfg.bias_en) else $error("cm default");
   a_pd_soft_reset: assert property (serial_port_enable_n && $fell(power_down_input) |->
      ##[1:4] cfg.cm_sel == `CM_DEFAULT) else $error("pd reset");
   a_out_latency: assert property (cfg.bus == BUS_DUAL && cfg.div == DIV_1 |->
      data_valid == $past(sample_valid, 9)) else $error("latency");
   a_oe_released: assert property (s_strap or s_quiet |=> sdo_oe_n) else $error("sdo enable");
   a_dclk_toggle: assert property ($past(rst_n, 2) |->
      $changed(chan_a_output_clock)) else $error("output clock");
endmodule
bind adc_ctrl adc_ctrl_chk i_adc_ctrl_chk (.core_clk, .rst_n, .serial_port_enable_n,
   .serial_in_or_format_strap, .div_strap, .port_select_or_bus_mode_strap,
   .power_down_input, .sample_valid, .cfg, .data_valid, .sdo_oe_n, .chan_a_output_clock);
`default_nettype wire

// ---- verif/test_adc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.svh"
module test_adc_ctrl
   import adc_ctrl_pkg::*;
;
   logic       core_clk = 0, rst_n = 0, strap_mode = 0, pd = 0, sv = 0, sdo, oe_n, dv, ck_a;
   tri_t       fmt_pin = TRI_LOW, div_pin = TRI_LOW, sel_pin = TRI_HIGH;
   pair_t      s_in = '0, d_out;
   cfg_t       cfg;
   logic [7:0] rd, rv;
   int         fails = 0, samples_checked = 0;
   pair_t      exp_q[$];
   adc_ctrl i_adc_ctrl (.core_clk, .rst_n, .serial_port_enable_n(strap_mode),
      .serial_in_or_format_strap(fmt_pin), .div_strap(div_pin),
      .port_select_or_bus_mode_strap(sel_pin), .power_down_input(pd), .sample_in(s_in),
      .sample_valid(sv), .sdo_oe_n(oe_n), .sdo, .cfg, .data_out(d_out), .data_valid(dv),
      .chan_a_output_clock(ck_a));
   adc_rx_model i_adc_rx_model (.core_clk, .data_out(d_out), .data_valid(dv),
      .chan_a_output_clock(ck_a));
   initial forever #10 core_clk = ~core_clk;
   initial
   begin
      #100000;
      fails++;
      test_done;
   end
   task test_done;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task check(input logic [15:0] seen, input logic [15:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         fails++;
         $display("wrong value at %0t: %h vs %h", $time, seen, want);
      end
   endtask
   task idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Sclk toggles at half the core rate so every edge is seen
   task frame(input logic r, input logic [6:0] ad, input logic [7:0] wd);
      logic [15:0] f;
      f = {r, ad, wd};
      idle(1);
      sel_pin = TRI_LOW;
      for (int i = 15; i >= 0; i--)
      begin
         idle(1);
         div_pin = TRI_LOW;
         fmt_pin = f[i] ? TRI_HIGH : TRI_LOW;
         idle(1);
         rd = {rd[6:0], sdo};
         div_pin = TRI_HIGH;
      end
      if (r) check(oe_n, 1'h0);
      idle(1);
      div_pin = TRI_LOW;
      sel_pin = TRI_HIGH;
   endtask
   function automatic logic [7:0] fmtf(input logic [7:0] x, input int f);
      logic [7:0] o;
      o = x ^ 8'h80;
      return f == 0 ? x : f == 1 ? o : o ^ (o >> 1);
   endfunction
   // Muxed buses carry channel A while the output clock is low
   function automatic pair_t expf(input pair_t s, input int f, input int m, input logic ph);
      logic [7:0] c;
      c = ph ? fmtf(s.b, f) : fmtf(s.a, f);
      case (m)
         1:       expf = '{a: c, b: 8'h0};
         2:       expf = '{a: 8'h0, b: c};
         default: expf = '{a: fmtf(s.a, f), b: fmtf(s.b, f)};
      endcase
   endfunction
   initial
   begin
      void'($urandom(32'he3dbd27f));
      idle(16);
      rst_n = 1;
      idle(1);
      check(cfg.cm_sel, `CM_DEFAULT);
      for (int i = 0; i < 4; i++)
      begin
         rv = {1'($urandom), 4'h0, i == 0 ? 3'h6 : 3'($urandom_range(6))};
         frame(`WR_BIT, `REG_CM, rv);
         idle(2);
         check({cfg.bias_en, 4'h0, cfg.cm_sel}, rv);
         frame(1'h1, `REG_CM, 8'($urandom));
         check(rd, rv);
      end
      fmt_pin = TRI_FLOAT;
      idle(5);
      check({cfg.fmt, cfg.bus}, {FMT_TWOS, BUS_DUAL});
      frame(`WR_BIT, `REG_CM, 8'h07);
      idle(2);
      check(cfg.cm_sel, rv[2:0]);
      frame(`WR_BIT, `REG_FMT, 8'h04);
      frame(`WR_BIT, `REG_DIV, 8'h02);
      idle(2);
      check({cfg.fmt, cfg.div}, {FMT_GRAY, DIV_4});
      frame(`WR_BIT, `REG_RST, `RST_KEY);
      idle(2);
      check({cfg.fmt, cfg.div, cfg.cm_sel}, {FMT_TWOS, DIV_1, `CM_DEFAULT});
      frame(`WR_BIT, `REG_CM, 8'h06);
      strap_mode = 1;
      pd = 1;
      idle(3);
      check(cfg.cm_sel, 3'h6);
      pd = 0;
      idle(4);
      check(cfg.cm_sel, `CM_DEFAULT);
      for (int k = 0; k < 3; k++)
      begin
         fmt_pin = tri_t'(k);
         div_pin = tri_t'((k + 1) % 3);
         sel_pin = tri_t'((k + 2) % 3);
         idle(2);
         check({cfg.fmt, cfg.div, cfg.bus}, {2'(k), 2'((k + 1) % 3), 2'((k + 2) % 3)});
      end
      for (int f = 0; f < 3; f++)
      begin
         fmt_pin = tri_t'(f);
         div_pin = TRI_LOW;
         sel_pin = tri_t'(f);
         idle(12);
         i_adc_rx_model.got.delete();
         i_adc_rx_model.ph.delete();
         exp_q.delete();
         for (int i = 0; i < 30; i++)
         begin
            s_in = i == 0 ? 16'h807f : 16'($urandom);
            sv = (i < 2) | 1'($urandom);
            if (sv) exp_q.push_back(s_in);
            idle(1);
         end
         sv = 0;
         idle(12);
         check(i_adc_rx_model.got.size(), exp_q.size());
         foreach (exp_q[j]) check(i_adc_rx_model.got[j], expf(exp_q[j], f, f, i_adc_rx_model.ph[j]));
      end
      test_done;
   end
endmodule
`default_nettype wire
